// File: sfr_params.svh
`ifndef SFR_PARAMS_SVH
`define SFR_PARAMS_SVH
`define SFR_BITS_PER_BYTE 8
`define SFR_OVR_BIT_IDX 7
`define SFR_RATE_RESET 2'h0
`define SFR_CNT_RESET 4'h0
`endif

// File: sfr_pkg.sv
`include "sfr_params.svh"
package sfr_pkg;
    typedef enum logic [1:0] {
        SFR_IDLE,
        SFR_XFER,
        SFR_DONE
    } sfr_state_type;
endpackage

// File: sfr_sync.sv
`timescale 1ns/100ps
module sfr_sync import sfr_pkg::*; #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Async in, synced out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    initial begin
        if (WIDTH < 1) begin
            $error("sfr_sync width must be positive");
        end
    end
    // Reset value is high so select and clocks start idle-high safe
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_ff <= '1;
            sync_out <= '1;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// File: sfr_top.sv
`timescale 1ns/100ps
`include "sfr_params.svh"
module sfr_top import sfr_pkg::*; #(
    parameter int BITS = `SFR_BITS_PER_BYTE
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control bits
    input wire logic port_enable_set,
    input wire logic port_enable_clr,
    input wire logic master_select_in,
    input wire logic mode_fault_enable_in,
    input wire logic error_irq_enable_in,
    input wire logic tx_irq_enable_in,
    input wire logic rx_irq_enable_in,
    input wire logic clock_phase_select_in,
    input wire logic clock_polarity_in,
    input wire logic [1:0] rate_select_in,
    input wire logic control_load,
    // CPU access strobes
    input wire logic status_read,
    input wire logic control_write,
    input wire logic data_read,
    input wire logic data_write,
    input wire logic [BITS-1:0] data_wdata,
    // SPI pins, slave side sampled
    input wire logic serial_clock_pin_in,
    input wire logic slave_select_n_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_n,
    output logic serial_clock_oe_n,
    output logic mosi_oe_n,
    // Status and requests
    output logic port_enable,
    output logic master_select,
    output logic [1:0] rate_select,
    output logic tx_empty_flag,
    output logic rx_full_flag,
    output logic overrun_flag,
    output logic mode_fault_flag,
    output logic [BITS-1:0] rx_data,
    output logic tx_irq,
    output logic rx_irq,
    output logic err_irq
);
    localparam int CW = $clog2(BITS + 1);
    initial begin
        if (BITS != `SFR_BITS_PER_BYTE) begin
            $error("sfr_top serves byte transfers only");
        end
    end

    logic [2:0] pins_sync;
    logic sck_s, ss_n_s, mosi_s;
    sfr_sync #(.WIDTH(3)) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({serial_clock_pin_in, slave_select_n_in, mosi_in}),
        .sync_out(pins_sync)
    );
    assign {sck_s, ss_n_s, mosi_s} = pins_sync;

    logic sck_d_ff, ss_d_ff;
    logic mode_fault_enable_ff, error_irq_enable_ff;
    logic tx_irq_enable_ff, rx_irq_enable_ff, clock_phase_select_ff, cpol_ff;
    logic tx_full_ff;
    logic [BITS-1:0] tx_buf_ff, shift_ff;
    logic [CW-1:0] cnt_ff;
    sfr_state_type state_ff;
    logic stat_mf_seen_ff, stat_rx_seen_ff;

    always_ff @(posedge clk) begin
        if (reset) begin
            sck_d_ff <= 1'b0;
            ss_d_ff <= 1'b1;
        end else begin
            sck_d_ff <= sck_s;
            ss_d_ff <= ss_n_s;
        end
    end

    // Derived conditions
    logic idle_lvl, sck_lead, sck_trail, ss_fall, slave_act;
    logic sample_edge, fault_master, fault_slave, fault_cond;
    logic byte_done, ovr_strobe;
    assign idle_lvl = cpol_ff;
    assign sck_lead = (sck_s != idle_lvl) && (sck_d_ff == idle_lvl);
    assign sck_trail = (sck_s == idle_lvl) && (sck_d_ff != idle_lvl);
    assign ss_fall = !ss_n_s && ss_d_ff;
    assign slave_act = port_enable && !master_select && !ss_n_s;
    assign sample_edge = clock_phase_select_ff ? sck_trail : sck_lead;
    assign fault_master = port_enable && master_select
        && mode_fault_enable_ff && !ss_n_s;
    assign fault_slave = port_enable && !master_select
        && mode_fault_enable_ff && ss_n_s && !ss_d_ff
        && (state_ff == SFR_XFER);
    assign fault_cond = fault_master || fault_slave;
    // Phase 1 takes its last bit on the closing edge, so the byte ends
    // one cycle after that edge, with the clock already back at idle
    assign byte_done = slave_act && (state_ff == SFR_XFER)
        && (cnt_ff == CW'(BITS)) && (clock_phase_select_ff || sck_trail);
    assign ovr_strobe = slave_act && (state_ff == SFR_XFER) && sample_edge
        && (cnt_ff == CW'(`SFR_OVR_BIT_IDX - 1)) && rx_full_flag;

    // Control bits survive port disable
    always_ff @(posedge clk) begin
        if (reset) begin
            master_select <= 1'b0;
            mode_fault_enable_ff <= 1'b0;
            error_irq_enable_ff <= 1'b0;
            tx_irq_enable_ff <= 1'b0;
            rx_irq_enable_ff <= 1'b0;
            clock_phase_select_ff <= 1'b1;
            cpol_ff <= 1'b0;
            rate_select <= `SFR_RATE_RESET;
        end else if (control_load) begin
            master_select <= master_select_in;
            mode_fault_enable_ff <= mode_fault_enable_in;
            error_irq_enable_ff <= error_irq_enable_in;
            tx_irq_enable_ff <= tx_irq_enable_in;
            rx_irq_enable_ff <= rx_irq_enable_in;
            clock_phase_select_ff <= clock_phase_select_in;
            cpol_ff <= clock_polarity_in;
            rate_select <= rate_select_in;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            port_enable <= 1'b0;
        end else if (fault_master) begin
            port_enable <= 1'b0;
        end else if (port_enable_clr) begin
            port_enable <= 1'b0;
        end else if (port_enable_set) begin
            port_enable <= 1'b1;
        end
    end

    // Transfer state machine for the slave role
    always_ff @(posedge clk) begin
        if (reset || !port_enable || fault_master) begin
            state_ff <= SFR_IDLE;
            cnt_ff <= CW'(`SFR_CNT_RESET);
            shift_ff <= '0;
        end else if (master_select || ss_n_s) begin
            state_ff <= SFR_IDLE;
            cnt_ff <= CW'(`SFR_CNT_RESET);
        end else begin
            case (state_ff)
                SFR_IDLE: begin
                    if ((!clock_phase_select_ff && ss_fall) || (clock_phase_select_ff && sck_lead)) begin
                        state_ff <= SFR_XFER;
                        shift_ff <= tx_buf_ff;
                    end
                end
                SFR_XFER: begin
                    if (sample_edge && cnt_ff < CW'(BITS)) begin
                        shift_ff <= {shift_ff[BITS-2:0], mosi_s};
                        cnt_ff <= cnt_ff + CW'(1);
                    end
                    if (byte_done) begin
                        state_ff <= SFR_DONE;
                        cnt_ff <= CW'(`SFR_CNT_RESET);
                    end
                end
                SFR_DONE: begin
                    // Phase 0 needs select toggled between bytes
                    if (clock_phase_select_ff) begin
                        state_ff <= SFR_IDLE;
                    end
                end
                default: state_ff <= SFR_IDLE;
            endcase
        end
    end

    logic load_shift;
    assign load_shift = slave_act && (state_ff == SFR_IDLE)
        && ((!clock_phase_select_ff && ss_fall) || (clock_phase_select_ff && sck_lead));

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_buf_ff <= '0;
            tx_full_ff <= 1'b0;
        end else if (data_write) begin
            tx_buf_ff <= data_wdata;
            tx_full_ff <= 1'b1;
        end else if (load_shift) begin
            tx_full_ff <= 1'b0;
        end
    end

    // Write clears empty, load or disable sets it; set wins
    always_ff @(posedge clk) begin
        if (reset || !port_enable || fault_master) begin
            tx_empty_flag <= 1'b1;
        end else if (load_shift && tx_full_ff) begin
            tx_empty_flag <= 1'b1;
        end else if (data_write) begin
            tx_empty_flag <= 1'b0;
        end
    end

    // Two-step clear tracking
    always_ff @(posedge clk) begin
        if (reset) begin
            stat_mf_seen_ff <= 1'b0;
            stat_rx_seen_ff <= 1'b0;
        end else begin
            if (fault_cond || control_write) begin
                stat_mf_seen_ff <= 1'b0;
            end
            if (status_read && mode_fault_flag && !fault_cond) begin
                stat_mf_seen_ff <= 1'b1;
            end
            if (data_read) begin
                stat_rx_seen_ff <= 1'b0;
            end
            if (status_read && (rx_full_flag || overrun_flag)) begin
                stat_rx_seen_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_fault_flag <= 1'b0;
        end else if (fault_cond) begin
            mode_fault_flag <= 1'b1;
        end else if (control_write && stat_mf_seen_ff) begin
            mode_fault_flag <= 1'b0;
        end
    end

    logic data_clear;
    assign data_clear = data_read && stat_rx_seen_ff;

    always_ff @(posedge clk) begin
        if (reset) begin
            overrun_flag <= 1'b0;
        end else if (ovr_strobe) begin
            overrun_flag <= 1'b1;
        end else if (data_clear) begin
            overrun_flag <= 1'b0;
        end
    end

    logic store_byte;
    assign store_byte = byte_done && !overrun_flag && !ovr_strobe;

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_full_flag <= 1'b0;
            rx_data <= '0;
        end else if (store_byte) begin
            rx_full_flag <= 1'b1;
            rx_data <= shift_ff;
        end else if (data_clear) begin
            rx_full_flag <= 1'b0;
        end
    end

    // Pins; enables are active low
    always_ff @(posedge clk) begin
        if (reset || !port_enable || fault_master) begin
            miso_out <= 1'b0;
            miso_oe_n <= 1'b1;
            serial_clock_oe_n <= 1'b1;
            mosi_oe_n <= 1'b1;
        end else begin
            miso_out <= (state_ff == SFR_IDLE) ? tx_buf_ff[BITS-1]
                : shift_ff[BITS-1];
            miso_oe_n <= master_select || ss_n_s;
            serial_clock_oe_n <= !master_select;
            mosi_oe_n <= !master_select;
        end
    end

    // Level requests from flags; is software's concern
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_irq <= 1'b0;
            rx_irq <= 1'b0;
            err_irq <= 1'b0;
        end else begin
            tx_irq <= tx_empty_flag && tx_irq_enable_ff
                && port_enable;
            rx_irq <= rx_full_flag && rx_irq_enable_ff;
            err_irq <= error_irq_enable_ff
                && (overrun_flag || mode_fault_flag);
        end
    end

    master_fault_a: assert property (@(posedge clk) disable iff (reset)
        fault_master |=> !port_enable && tx_empty_flag && mode_fault_flag)
        else $error("master fault did not disable port");
    fault_gate_a: assert property (@(posedge clk) disable iff (reset)
        $rose(mode_fault_flag) |-> $past(mode_fault_enable_ff))
        else $error("mode fault set while disabled");
    msel_keep_a: assert property (@(posedge clk) disable iff (reset)
        $rose(mode_fault_flag) && !$past(control_load)
        |-> $stable(master_select))
        else $error("master select changed on fault");
    slave_keep_a: assert property (@(posedge clk) disable iff (reset)
        fault_slave && !port_enable_clr |=> port_enable)
        else $error("slave fault disabled port");
    tx_irq_a: assert property (@(posedge clk) disable iff (reset)
        tx_irq |-> $past(tx_empty_flag && tx_irq_enable_ff && port_enable))
        else $error("tx request without cause");
    err_irq_a: assert property (@(posedge clk) disable iff (reset)
        error_irq_enable_ff && overrun_flag ##1 error_irq_enable_ff
        |-> err_irq)
        else $error("error request missing");
    rx_set_a: assert property (@(posedge clk) disable iff (reset)
        store_byte |=> rx_full_flag && rx_data == $past(shift_ff))
        else $error("byte not stored");
    ovr_block_a: assert property (@(posedge clk) disable iff (reset)
        overrun_flag && byte_done |=> $stable(rx_data))
        else $error("byte stored during overrun");
    tx_clear_a: assert property (@(posedge clk) disable iff (reset)
        $fell(tx_empty_flag) |-> $past(data_write))
        else $error("empty flag cleared without write");
    disable_a: assert property (@(posedge clk) disable iff (reset)
        !port_enable ##1 !port_enable |-> tx_empty_flag && miso_oe_n
        && state_ff == SFR_IDLE)
        else $error("disabled port not released");
    deselect_a: assert property (@(posedge clk) disable iff (reset)
        ss_n_s ##1 ss_n_s |-> miso_oe_n)
        else $error("deselected slave drives output");
    byte_c: cover property (@(posedge clk) disable iff (reset) store_byte);
    ovr_c: cover property (@(posedge clk) disable iff (reset) ovr_strobe);
    sfault_c: cover property (@(posedge clk) disable iff (reset)
        fault_slave);
    mfault_c: cover property (@(posedge clk) disable iff (reset)
        fault_master);
endmodule

// File: sfr_master_model.sv
`timescale 1ns/100ps
module sfr_master_model (
    // Clock
    input wire logic clk,
    // Link pins
    output logic sck,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    logic [7:0] got;

    initial begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
        got = 8'h00;
    end

    // A 400 ns link period is eight bus clocks
    task automatic half();
        repeat (4) @(posedge clk);
    endtask

    // Released data line shows the inverse, never a stale value
    task automatic sel(input logic lvl);
        @(posedge clk);
        ss_n <= lvl;
        if (lvl) mosi <= ~mosi;
        repeat (8) @(posedge clk);
    endtask

    // Clock stands idle low outside frames; MSB first
    task automatic xfer(input logic [7:0] d, input logic clock_phase_select);
        for (int i = 7; i >= 0; i--) begin
            if (!clock_phase_select) mosi <= d[i];
            half();
            // Taken just before the edge after which the slave moves on
            if (!clock_phase_select) got[i] = miso;
            sck <= 1'b1;
            if (clock_phase_select) mosi <= d[i];
            half();
            if (clock_phase_select) got[i] = miso;
            sck <= 1'b0;
        end
        half();
    endtask
endmodule

// File: sfr_top_tb.sv
`timescale 1ns/100ps
module sfr_top_tb;
    localparam logic [6:0] PS = 7'h40;
    localparam logic [6:0] PC = 7'h20;
    localparam logic [6:0] CL = 7'h10;
    localparam logic [6:0] SR = 7'h08;
    localparam logic [6:0] CW = 7'h04;
    localparam logic [6:0] DR = 7'h02;
    localparam logic [6:0] DW = 7'h01;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [6:0] stb = 7'h00;
    logic [4:0] ctl = 5'h00;
    logic [7:0] data_wdata = 8'h00;
    logic port_enable_set, port_enable_clr, control_load, status_read;
    logic control_write, data_read, data_write, master_select_in;
    logic mode_fault_enable_in, clock_phase_select_in;
    logic error_irq_enable_in, rx_irq_enable_in;
    logic miso_out, miso_oe_n, serial_clock_oe_n, mosi_oe_n, port_enable;
    logic master_select, tx_empty_flag, rx_full_flag, overrun_flag;
    logic mode_fault_flag, tx_irq, rx_irq, err_irq;
    logic [1:0] rate_select;
    logic [7:0] rx_data;
    wire logic sck, ss_n, mosi, miso;
    int miscompares = 0;
    int compares = 0;

    always #25 clk = ~clk;
    assign {port_enable_set, port_enable_clr, control_load, status_read,
        control_write, data_read, data_write} = stb;
    assign {master_select_in, mode_fault_enable_in, clock_phase_select_in,
        error_irq_enable_in, rx_irq_enable_in} = ctl;
    // A released slave output shows the inverse so a stale bit cannot pass
    assign miso = miso_oe_n ? ~miso_out : miso_out;

    sfr_top u_sfr_top (
        .clk, .reset, .port_enable_set, .port_enable_clr, .master_select_in,
        .mode_fault_enable_in, .error_irq_enable_in, .tx_irq_enable_in(1'b1),
        .rx_irq_enable_in, .clock_phase_select_in, .clock_polarity_in(1'b0),
        .rate_select_in(2'h2), .control_load, .status_read, .control_write,
        .data_read, .data_write, .data_wdata, .serial_clock_pin_in(sck),
        .slave_select_n_in(ss_n), .mosi_in(mosi), .miso_out, .miso_oe_n,
        .serial_clock_oe_n, .mosi_oe_n, .port_enable, .master_select,
        .rate_select, .tx_empty_flag, .rx_full_flag, .overrun_flag,
        .mode_fault_flag, .rx_data, .tx_irq, .rx_irq, .err_irq
    );

    sfr_master_model u_sfr_master_model (.clk, .sck, .ss_n, .mosi, .miso);

    task automatic results();
        if (miscompares == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    // Strobe is one cycle; waits out flag and request latency
    task automatic cpu(input logic [6:0] s, input logic [7:0] d = 8'h00);
        @(posedge clk);
        stb <= s;
        data_wdata <= d;
        @(posedge clk);
        stb <= 7'h00;
        repeat (3) @(posedge clk);
    endtask

    task automatic cfg(input logic [4:0] c);
        @(posedge clk);
        ctl <= c;
        cpu(CL);
    endtask

    task automatic sel(input logic l);
        u_sfr_master_model.sel(l);
    endtask

    task automatic slv(input logic [7:0] d, input logic p);
        sel(1'b0);
        u_sfr_master_model.xfer(d, p);
        sel(1'b1);
    endtask

    initial begin
        #1000000;
        miscompares++;
        results();
    end

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk("tx empty", 8'h01, tx_empty_flag);
        chk("flags", 8'h00,
            {rx_full_flag, overrun_flag, mode_fault_flag});
        chk("oe", 8'h07, {miso_oe_n, serial_clock_oe_n, mosi_oe_n});
        cfg(5'b01011);
        cpu(PS);
        chk("tx irq", 8'h01, tx_irq);
        chk("idle oe", 8'h07,
            {miso_oe_n, serial_clock_oe_n, mosi_oe_n});
        cpu(DW, 8'ha5);
        chk("tx empty/irq", 8'h00, {tx_empty_flag, tx_irq});
        sel(1'b0);
        chk("sel miso oe", 8'h00, miso_oe_n);
        chk("loaded", 8'h01, tx_empty_flag);
        u_sfr_master_model.xfer(8'h3c, 1'b0);
        sel(1'b1);
        chk("miso byte", 8'ha5, u_sfr_master_model.got);
        chk("rx data", 8'h3c, rx_data);
        chk("rx full/irq", 8'h03, {rx_full_flag, rx_irq});
        chk("no fault", 8'h00, mode_fault_flag);
        cpu(DR);
        chk("lone read", 8'h01, rx_full_flag);
        cpu(SR);
        cpu(DR);
        chk("rx clear", 8'h00, {rx_full_flag, rx_irq});
        slv(8'h11, 1'b0);
        slv(8'h22, 1'b0);
        chk("overrun/err", 8'h03, {overrun_flag, err_irq});
        slv(8'h33, 1'b0);
        chk("kept data", 8'h11, rx_data);
        cpu(SR);
        cpu(DR);
        cpu(SR);
        chk("ovr clear", 8'h00, {overrun_flag, rx_full_flag});
        slv(8'h44, 1'b0);
        chk("stored", 8'h44, rx_data);
        cpu(SR);
        cpu(DR);
        sel(1'b0);
        sel(1'b1);
        chk("slv fault", 8'h06,
            {mode_fault_flag, port_enable, master_select});
        chk("err irq", 8'h01, err_irq);
        cfg(5'b00000);
        chk("fault kept", 8'h02, {mode_fault_flag, err_irq});
        cpu(SR);
        cpu(CW);
        chk("fault clear", 8'h00, mode_fault_flag);
        sel(1'b0);
        sel(1'b1);
        chk("fault off", 8'h00, mode_fault_flag);
        cfg(5'b01100);
        sel(1'b0);
        sel(1'b1);
        chk("ph1 no fault", 8'h00, mode_fault_flag);
        slv(8'h5a, 1'b1);
        chk("ph1 byte", 8'h5a, rx_data);
        chk("ph1 miso", 8'ha5, u_sfr_master_model.got);
        chk("ph1 flags", 8'h02, {rx_full_flag, mode_fault_flag});
        cpu(SR);
        cpu(DR);
        cfg(5'b11011);
        chk("mst oe", 8'h01, {serial_clock_oe_n, mosi_oe_n, miso_oe_n});
        sel(1'b0);
        chk("mst fault", 8'h07, {port_enable, mode_fault_flag, tx_empty_flag,
            master_select});
        chk("mst oe off", 8'h07,
            {miso_oe_n, serial_clock_oe_n, mosi_oe_n});
        chk("gated tx", 8'h01, {tx_irq, err_irq});
        chk("rate", 8'h02, rate_select);
        sel(1'b1);
        cpu(SR);
        cpu(CW);
        cfg(5'b00000);
        cpu(PS);
        sel(1'b0);
        cpu(DW, 8'h77);
        chk("queued", 8'h00, tx_empty_flag);
        cpu(PC);
        chk("disabled", 8'h01, tx_empty_flag);
        chk("released", 8'h07,
            {miso_oe_n, serial_clock_oe_n, mosi_oe_n});
        sel(1'b1);
        results();
    end
endmodule
